// >>> core/kms_serial_port.sv
// Keyboard and pointer two-wire serial ports with their register slave.
// Assumes open-drain link wires resolved outside; pins arrive asynchronously.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns

module kms_channel
   import kms_pkg::*;
#(
   parameter int INHIBIT_CYC = KMS_INHIBIT_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [7:0] i_wdata,
   input wire logic i_ctl_wr,
   input wire logic i_dat_wr,
   input wire logic i_dat_rd,
   input wire logic i_clk_pin,
   input wire logic i_dat_pin,
   output logic o_clk_pin,
   output logic o_clk_pin_oe,
   output logic o_dat_pin,
   output logic o_dat_pin_oe,
   output logic [7:0] o_status,
   output logic [7:0] o_rx_data,
   output logic o_tx_irq,
   output logic o_rx_irq
);

   localparam logic [KMS_TMR_W-1:0] INHIBIT_LOAD = KMS_TMR_W'(INHIBIT_CYC - 1);

   kms_chan_s state_q;
   kms_chan_s state_d;

   // A level is accepted only once the second and third stages agree
   function automatic logic agreed(input logic [2:0] sy, input logic cur);
      logic res;
      res = cur;
      if (sy[1] == sy[2]) begin
         res = sy[2];
      end
      return res;
   endfunction

   logic clk_new;
   logic dat_new;
   logic clk_fall;
   logic clk_rise;

   always_comb begin
      clk_new = agreed(state_q.clk_sy, state_q.clk_lvl);
      dat_new = agreed(state_q.dat_sy, state_q.dat_lvl);
      clk_fall = state_q.clk_lvl & ~clk_new;
      clk_rise = ~state_q.clk_lvl & clk_new;
   end

   always_comb begin
      state_d = state_q;
      state_d.clk_sy = {state_q.clk_sy[1:0], i_clk_pin};
      state_d.dat_sy = {state_q.dat_sy[1:0], i_dat_pin};
      state_d.clk_lvl = clk_new;
      state_d.dat_lvl = dat_new;

      // only enable and force bits are stored
      if (i_ctl_wr) begin
         state_d.en = i_wdata[KMS_CTL_ENABLE];
         state_d.frc_dat = i_wdata[KMS_CTL_FORCE_DATA];
         state_d.frc_clk = i_wdata[KMS_CTL_FORCE_CLOCK];
      end

      // reading the data clears the full flag
      if (i_dat_rd) begin
         state_d.rx_full = 1'b0;
      end

      case (state_q.tx_st)
         KMS_TX_IDLE: begin
            // a write while idle and enabled loads the frame; writes while busy are dropped
            if (i_dat_wr && state_q.en) begin
               // data first, then odd parity, then stop
               state_d.tx_sh = {1'b1, ~^i_wdata, i_wdata};
               state_d.tx_cnt = 4'h0;
               state_d.tmr = INHIBIT_LOAD;
               // Host send takes priority; a partly received frame is dropped
               state_d.rx_busy = 1'b0;
               state_d.tx_st = KMS_TX_INHIBIT;
            end
         end
         KMS_TX_INHIBIT: begin
            // hold clock low for the inhibit time
            if (state_q.tmr == '0) begin
               // release clock, data low as request to send
               state_d.tx_bit = 1'b0;
               state_d.tx_st = KMS_TX_SEND;
            end else begin
               state_d.tmr = state_q.tmr - 1'b1;
            end
         end
         KMS_TX_SEND: begin
            // next bit driven on each falling clock
            if (clk_fall && state_q.tx_cnt < KMS_TX_SLOTS) begin
               state_d.tx_bit = state_q.tx_sh[0];
               state_d.tx_sh = {1'b1, state_q.tx_sh[9:1]};
               state_d.tx_cnt = state_q.tx_cnt + 1'b1;
            end
            // done once the stop bit is clocked; no acknowledge check
            if (clk_rise && state_q.tx_cnt == KMS_TX_SLOTS) begin
               state_d.tx_bit = 1'b1;
               state_d.tx_st = KMS_TX_IDLE;
            end
         end
         default: begin
            state_d.tx_st = KMS_TX_IDLE;
         end
      endcase

      // receiver samples data on each falling clock while the transmitter is idle
      if (state_q.tx_st == KMS_TX_IDLE && state_d.tx_st == KMS_TX_IDLE && clk_fall) begin
         if (!state_q.rx_busy) begin
            // low data at a falling clock is a start bit
            if (!state_q.dat_lvl) begin
               state_d.rx_busy = 1'b1;
               state_d.rx_cnt = 4'h0;
            end
         end else begin
            state_d.rx_cnt = state_q.rx_cnt + 1'b1;
            if (state_q.rx_cnt < KMS_DATA_BITS) begin
               // first bit lands in the low end
               state_d.rx_sh = {state_q.dat_lvl, state_q.rx_sh[7:1]};
            end else if (state_q.rx_cnt == KMS_PARITY_SLOT) begin
               state_d.rx_par = state_q.dat_lvl;
            end else begin
               // stop bit completes the byte; set wins over a read clear
               state_d.rx_data = state_q.rx_sh;
               state_d.rx_full = 1'b1;
               state_d.rx_busy = 1'b0;
            end
         end
      end else if (state_q.rx_cnt > KMS_STOP_SLOT) begin
         state_d.rx_cnt = 4'h0;
      end

      // disabled machine is cleared and held
      if (!state_d.en) begin
         state_d.tx_st = KMS_TX_IDLE;
         state_d.tmr = '0;
         state_d.tx_cnt = 4'h0;
         state_d.tx_bit = 1'b1;
         state_d.rx_busy = 1'b0;
         state_d.rx_cnt = 4'h0;
         state_d.rx_full = 1'b0;
         // Byte and parity are dropped too, so a re-enable never reports stale data
         state_d.tx_sh = 10'h3ff;
         state_d.rx_sh = KMS_BYTE_RESET;
         state_d.rx_data = KMS_BYTE_RESET;
         state_d.rx_par = 1'b0;
      end

      // clock driven only by force or inhibit
      state_d.clk_oe = state_d.frc_clk | (state_d.tx_st == KMS_TX_INHIBIT);
      // data driven by force or a low frame bit
      state_d.dat_oe = state_d.frc_dat | ((state_d.tx_st == KMS_TX_SEND) & ~state_d.tx_bit);
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         state_q <= '{
            en: 1'b0,
            frc_clk: 1'b0,
            frc_dat: 1'b0,
            clk_sy: 3'h7,
            dat_sy: 3'h7,
            clk_lvl: 1'b1,
            dat_lvl: 1'b1,
            tx_st: KMS_TX_IDLE,
            tmr: '0,
            tx_cnt: 4'h0,
            tx_sh: 10'h3ff,
            tx_bit: 1'b1,
            rx_busy: 1'b0,
            rx_cnt: 4'h0,
            rx_sh: KMS_BYTE_RESET,
            rx_data: KMS_BYTE_RESET,
            rx_full: 1'b0,
            rx_par: 1'b0,
            clk_oe: 1'b0,
            dat_oe: 1'b0
         };
      end else begin
         state_q <= state_d;
      end
   end

   // open-drain pins only ever pull low
   assign o_clk_pin = 1'b0;
   assign o_dat_pin = 1'b0;
   assign o_clk_pin_oe = state_q.clk_oe;
   assign o_dat_pin_oe = state_q.dat_oe;
   assign o_rx_data = state_q.rx_data;

   always_comb begin
      o_status = KMS_BYTE_RESET;
      o_status[KMS_ST_TX_EMPTY] = state_q.en & (state_q.tx_st == KMS_TX_IDLE);
      o_status[KMS_ST_TX_BUSY] = state_q.tx_st != KMS_TX_IDLE;
      o_status[KMS_ST_RX_FULL] = state_q.rx_full;
      o_status[KMS_ST_RX_BUSY] = state_q.rx_busy;
      o_status[KMS_ST_ENABLE] = state_q.en;
      o_status[KMS_ST_RX_PARITY] = state_q.rx_par;
      o_status[KMS_ST_DATA_PIN] = state_q.dat_lvl;
      o_status[KMS_ST_CLOCK_PIN] = state_q.clk_lvl;
   end

   // transmit request follows the empty flag
   assign o_tx_irq = state_q.en & (state_q.tx_st == KMS_TX_IDLE);
   // receive request follows the full flag
   assign o_rx_irq = state_q.rx_full;

endmodule

module kms_serial_port
   import kms_pkg::*;
#(
   parameter int INHIBIT_CYC = KMS_INHIBIT_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [31:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_key_link_clock_pin,
   output logic o_key_link_clock_pin,
   output logic o_key_link_clock_pin_oe,
   input wire logic i_key_link_data_pin,
   output logic o_key_link_data_pin,
   output logic o_key_link_data_pin_oe,
   input wire logic i_pointer_link_clock_pin,
   output logic o_pointer_link_clock_pin,
   output logic o_pointer_link_clock_pin_oe,
   input wire logic i_pointer_link_data_pin,
   output logic o_pointer_link_data_pin,
   output logic o_pointer_link_data_pin_oe,
   output logic o_key_tx_irq,
   output logic o_key_rx_irq,
   output logic o_pointer_tx_irq,
   output logic o_pointer_rx_irq
);

   kms_top_s state_q;
   kms_top_s state_d;

   logic [7:0] key_status;
   logic [7:0] key_rx_data;
   logic [7:0] ptr_status;
   logic [7:0] ptr_rx_data;

   logic key_ctl_sel;
   logic key_dat_sel;
   logic ptr_ctl_sel;
   logic ptr_dat_sel;

   assign key_ctl_sel = i_addr == KMS_KEY_CTL_ADDR;
   assign key_dat_sel = i_addr == KMS_KEY_DATA_ADDR;
   assign ptr_ctl_sel = i_addr == KMS_PTR_CTL_ADDR;
   assign ptr_dat_sel = i_addr == KMS_PTR_DATA_ADDR;

   kms_channel #(
      .INHIBIT_CYC(INHIBIT_CYC)
   ) u_key (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_wdata(i_wdata),
      .i_ctl_wr(i_wr & key_ctl_sel),
      .i_dat_wr(i_wr & key_dat_sel),
      .i_dat_rd(i_rd & key_dat_sel),
      .i_clk_pin(i_key_link_clock_pin),
      .i_dat_pin(i_key_link_data_pin),
      .o_clk_pin(o_key_link_clock_pin),
      .o_clk_pin_oe(o_key_link_clock_pin_oe),
      .o_dat_pin(o_key_link_data_pin),
      .o_dat_pin_oe(o_key_link_data_pin_oe),
      .o_status(key_status),
      .o_rx_data(key_rx_data),
      .o_tx_irq(o_key_tx_irq),
      .o_rx_irq(o_key_rx_irq)
   );

   kms_channel #(
      .INHIBIT_CYC(INHIBIT_CYC)
   ) u_ptr (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_wdata(i_wdata),
      .i_ctl_wr(i_wr & ptr_ctl_sel),
      .i_dat_wr(i_wr & ptr_dat_sel),
      .i_dat_rd(i_rd & ptr_dat_sel),
      .i_clk_pin(i_pointer_link_clock_pin),
      .i_dat_pin(i_pointer_link_data_pin),
      .o_clk_pin(o_pointer_link_clock_pin),
      .o_clk_pin_oe(o_pointer_link_clock_pin_oe),
      .o_dat_pin(o_pointer_link_data_pin),
      .o_dat_pin_oe(o_pointer_link_data_pin_oe),
      .o_status(ptr_status),
      .o_rx_data(ptr_rx_data),
      .o_tx_irq(o_pointer_tx_irq),
      .o_rx_irq(o_pointer_rx_irq)
   );

   // Read data stands for exactly the cycle after the strobe
   always_comb begin
      state_d.rdata = KMS_UNMAPPED_READ;
      if (i_rd) begin
         if (key_ctl_sel) begin
            state_d.rdata = key_status;
         end else if (key_dat_sel) begin
            state_d.rdata = key_rx_data;
         end else if (ptr_ctl_sel) begin
            state_d.rdata = ptr_status;
         end else if (ptr_dat_sel) begin
            state_d.rdata = ptr_rx_data;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         state_q <= '{rdata: KMS_UNMAPPED_READ};
      end else begin
         state_q <= state_d;
      end
   end

   assign o_rdata = state_q.rdata;

endmodule

// >>> core/kms_pkg.sv
// Constants, types and register map of the keyboard and pointer serial ports.
// Assumes a single core clock; all link pins are sampled on that clock.
package kms_pkg;

   // Register byte addresses
   localparam logic [31:0] KMS_KEY_DATA_ADDR = 32'h0320_0004;
   localparam logic [31:0] KMS_KEY_CTL_ADDR = 32'h0320_0008;
   localparam logic [31:0] KMS_PTR_DATA_ADDR = 32'h0320_00a8;
   localparam logic [31:0] KMS_PTR_CTL_ADDR = 32'h0320_00ac;

   // Control write fields
   localparam int KMS_CTL_ENABLE = 3;
   localparam int KMS_CTL_FORCE_DATA = 1;
   localparam int KMS_CTL_FORCE_CLOCK = 0;

   // Status read fields
   localparam int KMS_ST_TX_EMPTY = 7;
   localparam int KMS_ST_TX_BUSY = 6;
   localparam int KMS_ST_RX_FULL = 5;
   localparam int KMS_ST_RX_BUSY = 4;
   localparam int KMS_ST_ENABLE = 3;
   localparam int KMS_ST_RX_PARITY = 2;
   localparam int KMS_ST_DATA_PIN = 1;
   localparam int KMS_ST_CLOCK_PIN = 0;

   // Reset values
   localparam logic [7:0] KMS_BYTE_RESET = 8'h00;
   localparam logic [7:0] KMS_UNMAPPED_READ = 8'h00;

   // Frame layout: data bits, then parity, then stop
   localparam logic [3:0] KMS_DATA_BITS = 4'h8;
   localparam logic [3:0] KMS_PARITY_SLOT = 4'h8;
   localparam logic [3:0] KMS_STOP_SLOT = 4'h9;
   localparam logic [3:0] KMS_TX_SLOTS = 4'ha;

   // Timing: clock rate and the clock-inhibit time before a request to send
   localparam int KMS_CLK_MHZ = 250;
   localparam int KMS_INHIBIT_US = 100;
   localparam int KMS_INHIBIT_CYC = KMS_INHIBIT_US * KMS_CLK_MHZ;
   localparam int KMS_TMR_W = 16;

   typedef enum logic [1:0] {
      KMS_TX_IDLE = 2'b00,
      KMS_TX_INHIBIT = 2'b01,
      KMS_TX_SEND = 2'b10
   } kms_tx_e;

   typedef struct packed {
      logic en;
      logic frc_clk;
      logic frc_dat;
      logic [2:0] clk_sy;
      logic [2:0] dat_sy;
      logic clk_lvl;
      logic dat_lvl;
      kms_tx_e tx_st;
      logic [KMS_TMR_W-1:0] tmr;
      logic [3:0] tx_cnt;
      logic [9:0] tx_sh;
      logic tx_bit;
      logic rx_busy;
      logic [3:0] rx_cnt;
      logic [7:0] rx_sh;
      logic [7:0] rx_data;
      logic rx_full;
      logic rx_par;
      logic clk_oe;
      logic dat_oe;
   } kms_chan_s;

   typedef struct packed {
      logic [7:0] rdata;
   } kms_top_s;

endpackage

// >>> verification/kms_serial_port_monitor.sv
// Assertions on the serial port's register bus and link pins.
// Bound to the top module; sees only its ports.
`timescale 1ns/1ns
module kms_serial_port_monitor
   import kms_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [31:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic i_key_link_clock_pin,
   input wire logic o_key_link_clock_pin,
   input wire logic o_key_link_clock_pin_oe,
   input wire logic o_key_link_data_pin_oe,
   input wire logic o_pointer_link_data_pin_oe,
   input wire logic o_key_tx_irq,
   input wire logic o_key_rx_irq,
   input wire logic o_pointer_rx_irq
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   logic mapped;
   logic kcw;
   assign mapped = i_addr == KMS_KEY_DATA_ADDR || i_addr == KMS_KEY_CTL_ADDR
      || i_addr == KMS_PTR_DATA_ADDR || i_addr == KMS_PTR_CTL_ADDR;
   assign kcw = i_wr && i_addr == KMS_KEY_CTL_ADDR;

   property p_rdata_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not zero outside a read");
   property p_unmapped; i_rd && !mapped |=> o_rdata == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_open_drain; o_key_link_clock_pin == 1'b0; endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("clock pin drives high");
   property p_disable; kcw && !i_wdata[KMS_CTL_ENABLE] |=> !o_key_tx_irq && !o_key_rx_irq;
   endproperty
   a_disable: assert property (p_disable)
      else $error("interrupt after disable");
   property p_force_clk; kcw && i_wdata[KMS_CTL_FORCE_CLOCK] |=> o_key_link_clock_pin_oe;
   endproperty
   a_force_clk: assert property (p_force_clk)
      else $error("clock not forced low");
   property p_force_dat;
      i_wr && i_addr == KMS_PTR_CTL_ADDR && i_wdata[KMS_CTL_FORCE_DATA]
         |=> o_pointer_link_data_pin_oe;
   endproperty
   a_force_dat: assert property (p_force_dat)
      else $error("pointer data not forced low");
   property p_tx_start;
      i_wr && i_addr == KMS_KEY_DATA_ADDR && o_key_tx_irq
         |=> o_key_link_clock_pin_oe && !o_key_tx_irq;
   endproperty
   a_tx_start: assert property (p_tx_start)
      else $error("transmit did not inhibit clock");
   property p_rts;
      $rose(o_key_link_data_pin_oe)
         |-> $past(o_key_link_clock_pin_oe) || $past(i_wr) || !i_key_link_clock_pin;
   endproperty
   a_rts: assert property (p_rts)
      else $error("data pulled low without clock inhibit");
   property p_tx_irq_fall; $fell(o_key_tx_irq) |-> $past(i_wr); endproperty
   a_tx_irq_fall: assert property (p_tx_irq_fall)
      else $error("transmit interrupt dropped without a write");
   property p_rx_at_fall; $rose(o_key_rx_irq) |-> !i_key_link_clock_pin; endproperty
   a_rx_at_fall: assert property (p_rx_at_fall)
      else $error("receive completed away from a clock fall");
   property p_rx_clear;
      i_rd && i_addr == KMS_KEY_DATA_ADDR && o_key_rx_irq && i_key_link_clock_pin
         |=> !o_key_rx_irq;
   endproperty
   a_rx_clear: assert property (p_rx_clear)
      else $error("receive interrupt not cleared by read");
   c_key_rx: cover property ($rose(o_key_rx_irq));
   c_key_tx: cover property ($rose(o_key_tx_irq));
   c_ptr_rx: cover property ($rose(o_pointer_rx_irq));
endmodule

// >>> verification/kms_link_peer.sv
// Behavioural keyboard or pointer on one two-wire link.
// Assumes pulled-up wires resolved by the bench; pulls are active high.
`timescale 1ns/1ns
module kms_link_peer (
   input wire logic i_clk_line,
   input wire logic i_dat_line,
   output logic o_clk_pull,
   output logic o_dat_pull
);
   localparam int HALF = 32;
   initial begin
      o_clk_pull = 1'b0;
      o_dat_pull = 1'b0;
   end
   // start, lsb first, set before fall
   task automatic send(input logic [7:0] b);
      logic [10:0] f;
      f = {1'b1, ~^b, b, 1'b0};
      for (int i = 0; i < 11; i++) begin
         o_dat_pull = ~f[i];
         #HALF o_clk_pull = 1'b1;
         #HALF o_clk_pull = 1'b0;
      end
   endtask
   task automatic recv(output logic [9:0] f);
      wait (i_clk_line === 1'b1 && i_dat_line === 1'b0);
      #HALF;
      for (int i = 0; i < 10; i++) begin
         o_clk_pull = 1'b1;
         #HALF f[i] = i_dat_line;
         o_clk_pull = 1'b0;
         #HALF;
      end
   endtask
endmodule

// >>> verification/kms_serial_port_test.sv
// Self-checking bench for the keyboard and pointer serial ports.
// Both links carry a peer model; wires are pulled up when nobody pulls.
`timescale 1ns/1ns
module kms_serial_port_test
   import kms_pkg::*;
;
   logic clk, rst_b, wr, rd;
   logic [31:0] addr;
   logic [7:0] wdata, rdata;
   logic kc_oe, kd_oe, pc_oe, pd_oe, kc_pl, kd_pl, pc_pl, pd_pl;
   logic kt_irq, kr_irq, pt_irq, pr_irq;
   wire kc = !(kc_oe || kc_pl);
   wire kd = !(kd_oe || kd_pl);
   wire pc = !(pc_oe || pc_pl);
   wire pd = !(pd_oe || pd_pl);
   int fail_count = 0;
   int tests_run = 0;
   int cyc = 0;

   kms_serial_port #(.INHIBIT_CYC(50)) dut (.i_clk(clk), .i_rst_b(rst_b), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_key_link_clock_pin(kc), .o_key_link_clock_pin(), .o_key_link_clock_pin_oe(kc_oe),
      .i_key_link_data_pin(kd), .o_key_link_data_pin(), .o_key_link_data_pin_oe(kd_oe),
      .i_pointer_link_clock_pin(pc), .o_pointer_link_clock_pin(),
      .o_pointer_link_clock_pin_oe(pc_oe), .i_pointer_link_data_pin(pd),
      .o_pointer_link_data_pin(), .o_pointer_link_data_pin_oe(pd_oe),
      .o_key_tx_irq(kt_irq), .o_key_rx_irq(kr_irq),
      .o_pointer_tx_irq(pt_irq), .o_pointer_rx_irq(pr_irq));
   kms_link_peer key_peer (.i_clk_line(kc), .i_dat_line(kd), .o_clk_pull(kc_pl),
      .o_dat_pull(kd_pl));
   kms_link_peer ptr_peer (.i_clk_line(pc), .i_dat_line(pd), .o_clk_pull(pc_pl),
      .o_dat_pull(pd_pl));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Enabled port with both pins high
   function automatic logic [7:0] st_exp(input logic tx, input logic rx, input logic par);
      return {~tx, tx, rx, 1'b0, 1'b1, par, 2'b11};
   endfunction

   task automatic bus_wr(input logic [31:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [31:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         complete_run();
      end
   end

   initial begin
      logic [31:0] ca, da;
      logic [7:0] d, b, c;
      logic [9:0] f;
      int n;
      rst_b = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 32'h0000_0000;
      wdata = 8'h00;
      void'($urandom(55));
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      for (int p = 0; p < 2; p++) begin
         ca = p ? KMS_PTR_CTL_ADDR : KMS_KEY_CTL_ADDR;
         da = p ? KMS_PTR_DATA_ADDR : KMS_KEY_DATA_ADDR;
         bus_rd(ca, d);
         chk("status", 8'h03, d);
         bus_rd(32'h0320_0010, d);
         chk("unmapped", 8'h00, d);
         bus_wr(ca, 8'hf3);
         repeat (5) @(posedge clk);
         bus_rd(ca, d);
         chk("status", 8'h00, d);
         bus_wr(ca, 8'hfc);
         repeat (5) @(posedge clk);
         bus_rd(ca, d);
         chk("status", st_exp(1'b0, 1'b0, 1'b0), d);
         for (int k = 0; k < 4; k++) begin
            b = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
            c = ~b;
            fork
               if (p) ptr_peer.send(b); else key_peer.send(b);
               begin
                  repeat (60) @(posedge clk);
                  bus_rd(ca, d);
                  chk("rx_busy", 8'h10, d & 8'h10);
               end
            join
            repeat (4) @(posedge clk);
            chk("rx_irq", 8'h01, {7'h00, p ? pr_irq : kr_irq});
            bus_rd(ca, d);
            chk("status", st_exp(1'b0, 1'b1, ~^b), d);
            bus_rd(da, d);
            chk("rx_data", b, d);
            bus_rd(ca, d);
            chk("status", st_exp(1'b0, 1'b0, ~^b), d);
            bus_wr(da, c);
            bus_rd(ca, d);
            chk("tx_busy", st_exp(1'b1, 1'b0, ~^b), (d & 8'hfc) | 8'h03);
            if (p) ptr_peer.recv(f); else key_peer.recv(f);
            chk("tx_data", c, f[7:0]);
            chk("tx_tail", {6'h00, 1'b1, ~^c}, {6'h00, f[9], f[8]});
            n = 0;
            while ((p ? pt_irq : kt_irq) !== 1'b1 && n < 40) begin
               @(posedge clk);
               n++;
            end
            chk("tx_irq", 8'h01, {7'h00, p ? pt_irq : kt_irq});
            bus_rd(ca, d);
            chk("status", st_exp(1'b0, 1'b0, ~^b), d);
         end
         bus_wr(ca, 8'h00);
         repeat (5) @(posedge clk);
         bus_rd(ca, d);
         chk("status", 8'h03, d);
      end
      complete_run();
   end
endmodule

bind kms_serial_port kms_serial_port_monitor mon (.*);
